// *** hdl/decoder_defs.svh ***
// offsets, field positions, reset values and timing counts of the telegram decoder
`ifndef DECODER_DEFS_SVH
`define DECODER_DEFS_SVH

// -----------------------------------------------------------------
// sizes
// -----------------------------------------------------------------
`define NUM_CH 4
`define CH_W 2
`define NUM_BASIC 6
`define NUM_EXT 20

// -----------------------------------------------------------------
// register offsets inside one channel window (addr[7:6] = channel)
// -----------------------------------------------------------------
`define OFF_BASIC 6'h00
`define OFF_EXT 6'h10
`define OFF_TYPE 6'h30
`define OFF_PROF 6'h31
`define PAGE_HI 8'h00

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define TYPE_RST 8'hF6

// -----------------------------------------------------------------
// first payload byte fields and codes
// -----------------------------------------------------------------
`define BOW_BIT 4
`define ROCKER_HI 7
`define ROCKER_LO 5
`define SECOND_BIT 0
`define LIGHT_MASK 8'hF0
`define ALARM_CODE 8'h11
`define BATT_CODE 8'h30
`define WATER_CODE 8'h11
`define HANDLE_CLOSED 8'hF0
`define HANDLE_TILT 8'hD0

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define LONG_PRESS_MS 500
`define MCLK_KHZ 125000
`define PRESS_W 26

`endif

// *** hdl/decoder_pkg.sv ***
// types shared by the telegram decoder and its surroundings
package decoder_pkg;

    // per-channel decoding profile
    typedef enum logic [3:0] {
        PROF_RAW, PROF_PUSH, PROF_ROCK2, PROF_ROCK2_LIGHT, PROF_ROCK4,
        PROF_DETECT, PROF_WATER, PROF_HANDLE, PROF_VALVE1, PROF_VALVE6
    } equipment_profile_e;

    // one received telegram
    typedef struct packed {
        logic [7:0] telegram_type_field;
        logic [31:0] data;   // data[7:0] is the first payload byte
        logic [7:0] status;
    } telegram_s;

    // register port request
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

endpackage

// *** hdl/switch_telegram_decoder.sv ***
// telegram decoder: received switch telegrams into per-channel value slots
//
// Contract
// - decode payload into basic and extended value slots
// - valve channels request automatic response telegram; when several accept in one cycle, only the lowest is reported
// - unsupported profile stores raw payload layout
// - raw profile selectable for any channel
// - accept only when telegram type matches channel
// - push button: current, previous, older state
// - slot5 energy bow: released, short, long
// - slot6 counts telegrams since slot1 read
// - rocker button codes one to eight, history
// - rocker slot4 flags second action valid
// - light rocker stores raw code, three previous
// - detectors: alarm, low battery, water alert
// - handle position code and raw first byte
// - unused or unmapped registers read zero
`timescale 1ns/1ps
`include "decoder_defs.svh"

module switch_telegram_decoder #(
    parameter int LONG_PRESS_CYC = `LONG_PRESS_MS * `MCLK_KHZ
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // received telegrams
    input wire logic tel_valid,
    input wire decoder_pkg::telegram_s tel,
    // register port
    input wire decoder_pkg::reg_req_s req,
    output logic [15:0] rd_data_reg,
    // response request for valve channels
    output logic resp_valid_reg,
    output logic [`CH_W-1:0] resp_ch_reg
);
    import decoder_pkg::*;

    // -----------------------------------------------------------------
    // storage
    // -----------------------------------------------------------------
    logic [7:0] type_reg [`NUM_CH];          // accepted telegram type
    logic [3:0] prof_reg [`NUM_CH];          // profile code as written
    logic [15:0] slot_reg [`NUM_CH][`NUM_BASIC]; // decoded value slots
    logic [15:0] tcnt_reg [`NUM_CH];         // telegrams since slot1 read
    logic pressed_reg [`NUM_CH];             // energy bow held
    logic [`PRESS_W-1:0] hold_reg [`NUM_CH]; // press duration
    logic [`NUM_CH-1:0] acc;                 // channel takes this telegram
    logic [`NUM_CH-1:0] clr;                 // slot1 read of channel
    logic [15:0] rd_next;                    // read word
    logic [7:0] db0;                         // first payload byte
    logic [`CH_W-1:0] a_ch;                  // addressed channel
    logic [5:0] a_off;                       // addressed offset
    logic a_hit;                             // address inside a window

    assign db0 = tel.data[7:0];
    assign a_ch = req.addr[7:6];
    assign a_off = req.addr[5:0];
    assign a_hit = (req.addr[15:8] == `PAGE_HI);

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    // unknown codes fall back to raw
    function automatic equipment_profile_e prof_of(input logic [3:0] p);
        equipment_profile_e r;
        r = PROF_RAW;
        if (p <= 4'(PROF_VALVE6)) begin
            r = equipment_profile_e'(p);
        end
        return r;
    endfunction

    // profiles with energy bow and telegram counter
    function automatic logic is_switch(input equipment_profile_e p);
        return (p == PROF_PUSH) || (p == PROF_ROCK2) ||
               (p == PROF_ROCK2_LIGHT) || (p == PROF_ROCK4);
    endfunction

    // rocker button code, zero when released
    function automatic logic [15:0] rocker_code(input logic [7:0] b);
        logic [3:0] c;
        c = {1'b0, b[`ROCKER_HI:`ROCKER_LO]} + 4'h1;
        return b[`BOW_BIT] ? {12'h000, c} : 16'h0000;
    endfunction

    // -----------------------------------------------------------------
    // channel acceptance and read clear
    // -----------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < `NUM_CH; c++) begin
            // type field must equal the channel's configured type
            acc[c] = tel_valid && (tel.telegram_type_field == type_reg[c]);
            // reading slot 1 restarts the count
            clr[c] = req.rd && a_hit && (a_ch == `CH_W'(c)) && (a_off == `OFF_BASIC);
        end
    end

    // -----------------------------------------------------------------
    // configuration registers
    // -----------------------------------------------------------------
    // software writes type and profile; raw may be chosen anywhere
    always_ff @(posedge mclk) begin
        for (int c = 0; c < `NUM_CH; c++) begin
            if (rst) begin
                type_reg[c] <= `TYPE_RST;
                prof_reg[c] <= 4'(PROF_RAW);
            end else if (req.wr && a_hit && (a_ch == `CH_W'(c))) begin
                if (a_off == `OFF_TYPE) begin
                    type_reg[c] <= req.wdata[7:0];
                end
                if (a_off == `OFF_PROF) begin
                    prof_reg[c] <= req.wdata[3:0];
                end
            end
        end
    end

    // -----------------------------------------------------------------
    // value slot decoding
    // -----------------------------------------------------------------
    // each accepted telegram updates its channel's slots
    always_ff @(posedge mclk) begin
        for (int c = 0; c < `NUM_CH; c++) begin
            if (rst) begin
                for (int s = 0; s < `NUM_BASIC; s++) begin
                    slot_reg[c][s] <= 16'h0000;
                end
            end else if (acc[c]) begin
                unique case (prof_of(prof_reg[c]))
                    PROF_PUSH: begin
                        // shift history, then new state
                        slot_reg[c][2] <= slot_reg[c][1];
                        slot_reg[c][1] <= slot_reg[c][0];
                        slot_reg[c][0] <= {15'h0000, db0[`BOW_BIT]};
                        slot_reg[c][3] <= 16'h0000;
                    end
                    PROF_ROCK2, PROF_ROCK4: begin
                        // button code with two older codes
                        slot_reg[c][2] <= slot_reg[c][1];
                        slot_reg[c][1] <= slot_reg[c][0];
                        slot_reg[c][0] <= rocker_code(db0);
                        // second action flag
                        slot_reg[c][3] <= {15'h0000, db0[`SECOND_BIT]};
                    end
                    PROF_ROCK2_LIGHT: begin
                        // raw code with three older codes
                        slot_reg[c][3] <= slot_reg[c][2];
                        slot_reg[c][2] <= slot_reg[c][1];
                        slot_reg[c][1] <= slot_reg[c][0];
                        slot_reg[c][0] <= {8'h00, db0 & `LIGHT_MASK};
                    end
                    PROF_DETECT: begin
                        // alarm and low battery flags
                        slot_reg[c][0] <= {15'h0000, db0 == `ALARM_CODE};
                        slot_reg[c][1] <= {15'h0000, db0 == `BATT_CODE};
                    end
                    PROF_WATER: begin
                        // water alert flag
                        slot_reg[c][0] <= {15'h0000, db0 == `WATER_CODE};
                    end
                    PROF_HANDLE: begin
                        // closed 0, tilted 2, anything else open 1
                        if (db0 == `HANDLE_CLOSED) begin
                            slot_reg[c][0] <= 16'h0000;
                        end else if (db0 == `HANDLE_TILT) begin
                            slot_reg[c][0] <= 16'h0002;
                        end else begin
                            slot_reg[c][0] <= 16'h0001;
                        end
                        slot_reg[c][1] <= {8'h00, db0};
                    end
                    default: begin
                        // raw layout: bytes and status
                        slot_reg[c][0] <= {8'h00, db0};
                        slot_reg[c][1] <= {8'h00, tel.status};
                        slot_reg[c][2] <= {8'h00, tel.data[15:8]};
                        slot_reg[c][3] <= {8'h00, tel.data[23:16]};
                        slot_reg[c][4] <= {8'h00, tel.data[31:24]};
                    end
                endcase
            end
        end
    end

    // -----------------------------------------------------------------
    // energy bow timing
    // -----------------------------------------------------------------
    // press held since last telegram; duration saturates at the limit
    always_ff @(posedge mclk) begin
        for (int c = 0; c < `NUM_CH; c++) begin
            if (rst) begin
                pressed_reg[c] <= 1'b0;
                hold_reg[c] <= '0;
            end else if (acc[c] && is_switch(prof_of(prof_reg[c]))) begin
                if (db0[`BOW_BIT] && !pressed_reg[c]) begin
                    hold_reg[c] <= '0;
                end
                pressed_reg[c] <= db0[`BOW_BIT];
            end else if (pressed_reg[c] && hold_reg[c] < `PRESS_W'(LONG_PRESS_CYC)) begin
                hold_reg[c] <= hold_reg[c] + `PRESS_W'(1);
            end
        end
    end

    // -----------------------------------------------------------------
    // telegram counters
    // -----------------------------------------------------------------
    // a telegram in the clearing cycle counts as the first one
    always_ff @(posedge mclk) begin
        for (int c = 0; c < `NUM_CH; c++) begin
            if (rst) begin
                tcnt_reg[c] <= 16'h0000;
            end else if (acc[c] && is_switch(prof_of(prof_reg[c]))) begin
                if (clr[c]) begin
                    tcnt_reg[c] <= 16'h0001;
                end else if (tcnt_reg[c] != 16'hFFFF) begin
                    tcnt_reg[c] <= tcnt_reg[c] + 16'h0001;
                end
            end else if (clr[c]) begin
                tcnt_reg[c] <= 16'h0000;
            end
        end
    end

    // -----------------------------------------------------------------
    // valve response request
    // -----------------------------------------------------------------
    // one pulse per accepted valve telegram; only the lowest accepting channel is reported
    always_ff @(posedge mclk) begin
        if (rst) begin
            resp_valid_reg <= 1'b0;
            resp_ch_reg <= '0;
        end else begin
            resp_valid_reg <= 1'b0;
            for (int c = `NUM_CH - 1; c >= 0; c--) begin
                if (acc[c] && (prof_of(prof_reg[c]) == PROF_VALVE1 ||
                               prof_of(prof_reg[c]) == PROF_VALVE6)) begin
                    resp_valid_reg <= 1'b1;
                    resp_ch_reg <= `CH_W'(c);
                end
            end
        end
    end

    // -----------------------------------------------------------------
    // register read
    // -----------------------------------------------------------------
    // slot word selection; everything unmapped reads zero
    always_comb begin
        logic [4:0] k;
        k = 5'h00;
        rd_next = 16'h0000;
        if (a_hit && a_off >= `OFF_EXT && a_off < `OFF_EXT + 6'(`NUM_EXT)) begin
            k = 5'(a_off - `OFF_EXT);
        end else if (a_hit && a_off < 6'(`NUM_BASIC)) begin
            k = 5'(a_off);
        end else begin
            k = 5'h1F;
        end
        if (a_hit && a_off == `OFF_TYPE) begin
            rd_next = {8'h00, type_reg[a_ch]};
        end else if (a_hit && a_off == `OFF_PROF) begin
            rd_next = {12'h000, prof_reg[a_ch]};
        end else if (k == 5'h04 && is_switch(prof_of(prof_reg[a_ch]))) begin
            // energy bow state
            if (!pressed_reg[a_ch]) begin
                rd_next = 16'h0000;
            end else if (hold_reg[a_ch] >= `PRESS_W'(LONG_PRESS_CYC)) begin
                rd_next = 16'h0002;
            end else begin
                rd_next = 16'h0001;
            end
        end else if (k == 5'h05 && is_switch(prof_of(prof_reg[a_ch]))) begin
            rd_next = tcnt_reg[a_ch];
        end else if (k < 5'(`NUM_BASIC)) begin
            rd_next = slot_reg[a_ch][3'(k)];
        end
    end

    // read data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_data_reg <= 16'h0000;
        end else begin
            rd_data_reg <= req.rd ? rd_next : 16'h0000;
        end
    end

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    AST_TYPE_FILTER: assert property (
        tel_valid && tel.telegram_type_field != type_reg[0] && !req.wr
        |=> $stable(slot_reg[0][0])) else $error("foreign type changed slot");
    AST_PUSH_STATE: assert property (
        acc[0] && prof_reg[0] == 4'(PROF_PUSH)
        |=> slot_reg[0][0] == {15'h0000, $past(db0[`BOW_BIT])}) else $error("push state");
    AST_HISTORY_SHIFT: assert property (
        acc[1] && prof_reg[1] == 4'(PROF_ROCK4)
        |=> slot_reg[1][1] == $past(slot_reg[1][0])) else $error("history not shifted");
    AST_ROCKER_CODE: assert property (
        acc[1] && prof_reg[1] == 4'(PROF_ROCK4) && db0[7:4] == 4'hF
        |=> slot_reg[1][0] == 16'h0008) else $error("rocker code wrong");
    AST_COUNT_CLEAR: assert property (
        clr[0] && !acc[0] |=> tcnt_reg[0] == 16'h0000) else $error("count not cleared");
    AST_COUNT_STEP: assert property (
        acc[0] && prof_reg[0] == 4'(PROF_PUSH) && !clr[0] && tcnt_reg[0] < 16'h0010
        |=> tcnt_reg[0] == $past(tcnt_reg[0]) + 16'h0001) else $error("count step");
    AST_VALVE_RESP: assert property (
        acc[2] && !acc[1] && !acc[0] && prof_reg[2] == 4'(PROF_VALVE1)
        |=> resp_valid_reg && resp_ch_reg == 2'h2) else $error("no valve response");
    AST_UNMAPPED_ZERO: assert property (
        req.rd && !a_hit |=> rd_data_reg == 16'h0000) else $error("unmapped not zero");
    AST_RAW_LAYOUT: assert property (
        acc[2] && prof_reg[2] == 4'(PROF_RAW)
        |=> slot_reg[2][0] == {8'h00, $past(db0)}) else $error("raw layout");
    AST_HANDLE_TILT: assert property (
        acc[3] && prof_reg[3] == 4'(PROF_HANDLE) && db0 == `HANDLE_TILT
        |=> slot_reg[3][0] == 16'h0002 ##0 slot_reg[3][1] == 16'h00D0) else $error("handle");

endmodule

// *** verif/telegram_sender.sv ***
// model of the wireless senders that feed the telegram decoder
`timescale 1ns/1ps
module telegram_sender (
    // clock
    input wire logic mclk,
    // received telegram
    output logic tel_valid,
    output decoder_pkg::telegram_s tel
);
    import decoder_pkg::*;

    // ------------------------------------------------------------
    // idle state and send task
    // ------------------------------------------------------------
    // bus starts idle
    initial begin
        tel_valid = 1'b0;
        tel = '0;
    end

    // one telegram for one cycle, then gap idle cycles (slow sender)
    task automatic send(input logic [7:0] ttype, input logic [31:0] data,
                        input logic [7:0] status, input int gap);
        telegram_s t;
        t = {ttype, data, status};  // sender's own payload, whatever the channel decodes
        @(posedge mclk);
        tel_valid <= 1'b1;
        tel <= t;
        @(posedge mclk);
        tel_valid <= 1'b0;
        tel <= ~t;  // no stale telegram left on the idle bus
        repeat (gap) @(posedge mclk);
    endtask
endmodule

// *** verif/test_switch_telegram_decoder.sv ***
// self-checking bench of the switch telegram decoder
`timescale 1ns/1ps
`include "decoder_defs.svh"
module test_switch_telegram_decoder;
    import decoder_pkg::*;

    // ------------------------------------------------------------
    // signals and counters
    // ------------------------------------------------------------
    localparam int HOLD_CYC = 20;  // shortened long-press count
    logic mclk = 1'b0;
    logic rst = 1'b1;
    reg_req_s req = '0;
    logic tel_valid;
    telegram_s tel;
    logic [15:0] rd_data_reg;
    logic resp_valid_reg;
    logic [`CH_W-1:0] resp_ch_reg;
    int failures = 0;
    int comparisons = 0;

    // clock of 8 ns
    always #4 mclk = ~mclk;

    // design and sender model
    switch_telegram_decoder #(.LONG_PRESS_CYC(HOLD_CYC)) uut (
        .mclk(mclk), .rst(rst), .tel_valid(tel_valid), .tel(tel), .req(req),
        .rd_data_reg(rd_data_reg), .resp_valid_reg(resp_valid_reg), .resp_ch_reg(resp_ch_reg));
    telegram_sender sender (.mclk(mclk), .tel_valid(tel_valid), .tel(tel));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    // verdict and end of run
    task automatic finish_test();
        if (failures == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // compare one value
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // register address of a channel offset
    function automatic logic [15:0] ad(input int ch, input logic [5:0] off);
        ad = {`PAGE_HI, 2'(ch), off};
    endfunction

    // one-cycle register write
    task automatic wr(input logic [15:0] addr, input logic [15:0] data);
        @(posedge mclk);
        req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        req <= '0;
    endtask

    // one-cycle register read, data checked in the following cycle
    task automatic rd(input logic [15:0] addr, input logic [15:0] exp, input string what);
        @(posedge mclk);
        req <= '{addr: addr, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        req <= '0;
        #1;
        chk(what, rd_data_reg, exp);
    endtask

    // set a channel 3 profile, send one byte, check slot 1 and maybe slot 2
    task automatic sensor(input logic [3:0] prof, input logic [7:0] db,
                          input logic [15:0] e1, input bit do2, input logic [15:0] e2);
        wr(ad(3, `OFF_PROF), {12'h000, prof});
        sender.send(8'hF6, {24'h000000, db}, 8'h30, 1);
        rd(ad(3, 6'h00), e1, "sensor slot 1");
        if (do2) begin
            rd(ad(3, 6'h01), e2, "sensor slot 2");
        end
    endtask

    // ------------------------------------------------------------
    // watchdog and main sequence
    // ------------------------------------------------------------
    // bounded run length
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        finish_test();
    end

    // scenarios
    initial begin
        int k;
        logic [7:0] db;
        logic [7:0] codes [4];
        logic [3:0] rawp [4];
        codes = '{8'h37, 8'h10, 8'h70, 8'h50};
        rawp = '{4'h0, 4'hC, 4'h8, 4'h9};
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        // reset values and refused accesses
        rd(ad(0, `OFF_TYPE), 16'h00F6, "type reset");
        @(posedge mclk);
        #1;
        chk("read data idle", rd_data_reg, 16'h0000);
        rd(ad(0, `OFF_PROF), 16'h0000, "profile reset");
        wr(ad(0, 6'h00), 16'h1234);
        rd(ad(0, 6'h00), 16'h0000, "slot write ignored");
        rd(16'h0100, 16'h0000, "unmapped page");
        rd(ad(3, 6'h3F), 16'h0000, "unmapped offset");
        rd(ad(1, 6'h16), 16'h0000, "extended slot 7");
        // channel set-up: one sender type on three channels
        wr(ad(0, `OFF_PROF), {12'h000, PROF_PUSH});
        wr(ad(1, `OFF_PROF), {12'h000, PROF_ROCK4});
        wr(ad(2, `OFF_TYPE), 16'h00D5);
        wr(ad(3, `OFF_PROF), {12'h000, PROF_HANDLE});
        // push button history, bow and counter
        sender.send(8'hF6, 32'h00000010, 8'h30, 0);
        sender.send(8'hF6, 32'h00000000, 8'h20, 3);
        sender.send(8'hF6, 32'h00000010, 8'h30, 0);
        rd(ad(0, 6'h04), 16'h0001, "bow short");
        repeat (HOLD_CYC + 5) @(posedge mclk);
        rd(ad(0, 6'h04), 16'h0002, "bow long");
        rd(ad(0, 6'h05), 16'h0003, "telegram count");
        rd(ad(0, 6'h00), 16'h0001, "push now");
        rd(ad(0, 6'h01), 16'h0000, "push previous");
        rd(ad(0, 6'h02), 16'h0001, "push older");
        rd(ad(0, 6'h03), 16'h0000, "push reserved");
        rd(ad(0, 6'h05), 16'h0000, "count cleared");
        rd(ad(0, `OFF_EXT), 16'h0001, "extended mirror");
        rd(ad(3, 6'h00), 16'h0001, "handle open");
        sender.send(8'hF6, 32'h00000000, 8'h20, 0);
        rd(ad(0, 6'h04), 16'h0000, "bow released");
        rd(ad(0, 6'h05), 16'h0001, "count one");
        rd(ad(1, 6'h00), 16'h0000, "rocker released");
        // four-rocker codes, history and second action
        for (k = 0; k < 8; k++) begin
            db = {k[2:0], 1'b1, 3'b000, k[0]};
            sender.send(8'hF6, {24'h000000, db}, 8'h30, k % 2);
            rd(ad(1, 6'h00), 16'(k + 1), "rocker code");
            rd(ad(1, 6'h01), 16'((k == 0) ? 0 : k), "rocker previous");
            rd(ad(1, 6'h02), 16'((k == 1) ? 0 : (k == 0) ? 1 : k - 1), "rocker older");
            rd(ad(1, 6'h03), 16'(k % 2), "second action");
        end
        // light rocker keeps raw codes
        wr(ad(1, `OFF_PROF), {12'h000, PROF_ROCK2_LIGHT});
        foreach (codes[j]) sender.send(8'hF6, {24'h000000, codes[j]}, 8'h30, 0);
        for (k = 0; k < 4; k++) begin
            rd(ad(1, 6'(k)), {8'h00, codes[3 - k] & 8'hF0}, "light code");
        end
        wr(ad(1, `OFF_PROF), {12'h000, PROF_ROCK2});
        sender.send(8'hF6, 32'h00000070, 8'h30, 0);
        rd(ad(1, 6'h00), 16'h0004, "two-rocker code");
        // detectors and handle
        sensor(PROF_DETECT, 8'h11, 16'h0001, 1'b1, 16'h0000);
        sensor(PROF_DETECT, 8'h30, 16'h0000, 1'b1, 16'h0001);
        sensor(PROF_WATER, 8'h11, 16'h0001, 1'b0, 16'h0000);
        sensor(PROF_WATER, 8'h30, 16'h0000, 1'b0, 16'h0000);
        sensor(PROF_HANDLE, 8'hF0, 16'h0000, 1'b1, 16'h00F0);
        sensor(PROF_HANDLE, 8'hD0, 16'h0002, 1'b1, 16'h00D0);
        sensor(PROF_HANDLE, 8'hE0, 16'h0001, 1'b1, 16'h00E0);
        // raw, unsupported and valve profiles on another telegram type
        rd(ad(2, 6'h00), 16'h0000, "other type ignored");
        for (k = 0; k < 4; k++) begin
            wr(ad(2, `OFF_PROF), {12'h000, rawp[k]});
            sender.send(8'hD5, 32'h44332211 + k, 8'h5A, 0);
            #1;
            chk("valve request", {15'h0000, resp_valid_reg}, 16'(k >= 2));
            if (k >= 2) chk("valve channel", 16'(resp_ch_reg), 16'h0002);
            rd(ad(2, `OFF_PROF), {12'h000, rawp[k]}, "profile readback");
            rd(ad(2, 6'h00), 16'(8'h11 + k), "raw byte 0");
            rd(ad(2, 6'h01), 16'h005A, "raw status");
            rd(ad(2, 6'h04), 16'h0044, "raw byte 3");
        end
        rd(ad(3, 6'h00), 16'h0001, "handle kept");
        finish_test();
    end
endmodule
